// ===== src/disc_ctrl_params.svh
`ifndef DISC_CTRL_PARAMS_SVH
`define DISC_CTRL_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define ADDR_DEC_B 8'h00
`define ADDR_DEC_E 8'h04
`define ADDR_SHADOW3 8'h08
`define ADDR_STATUS 8'h0C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DEC_B_SPEED_BIT 3
`define DEC_B_SRC_BIT 2
`define DEC_B_STBY_MSB 1
`define DEC_B_STBY_LSB 0
`define DEC_E_QUAD_BIT 3
`define DEC_E_LOCK_BIT 0
`define SHADOW3_HCLK_EN_BIT 0
`define DEC_B_RESET 4'h0
`define DEC_E_RESET 4'h0
`define SHADOW3_RESET 4'h0
`define STBY_CODE_STOP 2'h1
`define STBY_CODE_PAUSE 2'h2

// ----------------------------------------------------------------
// clock rates in Hz
// ----------------------------------------------------------------
`define MCLK_HZ 125000000
`define HOST_CLK_FAST_HZ 11289600
`define HOST_CLK_SLOW_HZ 5644800

`endif

// ===== src/disc_ctrl_pkg.sv
package disc_ctrl_pkg;

	typedef enum logic [1:0]
	{
		SPEED_N1 = 2'b00,
		SPEED_N2 = 2'b01,
		SPEED_N4 = 2'b10
	} speed_t;

	typedef enum logic [1:0]
	{
		XTAL_33M = 2'b00,
		XTAL_16M = 2'b01,
		XTAL_8M = 2'b10
	} xtal_t;

	typedef enum logic [1:0]
	{
		MODE_RUN = 2'b00,
		MODE_STOP = 2'b01,
		MODE_PAUSE = 2'b10
	} standby_t;

	typedef struct packed
	{
		logic bit_clk;
		logic word_clk;
		logic data;
		logic c2_error_flag;
		logic biphase_mark;
	} audio_pins_t;

	typedef struct packed
	{
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

// ===== src/disc_speed_standby_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "disc_ctrl_params.svh"
module disc_speed_standby_ctrl (
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic multiplier_select_in,
	input wire logic motor_a_in,
	input wire logic motor_b_in,
	output logic motor_drive_out_a,
	output logic motor_drive_out_b,
	output logic motor_drive_oe_a,
	output logic motor_drive_oe_b,
	input wire disc_ctrl_pkg::audio_pins_t audio_in,
	output disc_ctrl_pkg::audio_pins_t audio_out,
	output logic audio_oe,
	input wire logic correction_flag_in,
	output logic correction_flag_out,
	input wire logic disc_rate_tick,
	input wire logic xtal_rate_tick,
	output logic audio_rate_tick,
	output logic fifo_bypass,
	output logic core_active,
	output logic host_clock_out_pin,
	output logic host_clock_oe,
	output disc_ctrl_pkg::speed_t speed_factor,
	output disc_ctrl_pkg::xtal_t xtal_source,
	output logic stop_standby,
	output logic pause_standby
);
	import disc_ctrl_pkg::*;

	localparam logic [31:0] INC_FAST =
		32'((64'(`HOST_CLK_FAST_HZ) * 64'd2 * (64'd1 << 32)) / 64'(`MCLK_HZ));
	localparam logic [31:0] INC_SLOW =
		32'((64'(`HOST_CLK_SLOW_HZ) * 64'd2 * (64'd1 << 32)) / 64'(`MCLK_HZ));

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	function automatic speed_t decode_speed(input logic [3:0] b, input logic [3:0] e);
		speed_t s;
		if (e[`DEC_E_QUAD_BIT])
			s = SPEED_N4;
		else if (b[`DEC_B_SPEED_BIT])
			s = SPEED_N2;
		else
			s = SPEED_N1;
		return s;
	endfunction

	function automatic xtal_t decode_xtal(input logic [3:0] b, input logic mult);
		xtal_t x;
		if (b[`DEC_B_SRC_BIT])
			x = XTAL_16M;
		else if (mult)
			x = XTAL_8M;
		else
			x = XTAL_33M;
		return x;
	endfunction

	function automatic standby_t decode_standby(input logic [3:0] b);
		standby_t m;
		case (b[`DEC_B_STBY_MSB:`DEC_B_STBY_LSB])
			`STBY_CODE_STOP: m = MODE_STOP;
			`STBY_CODE_PAUSE: m = MODE_PAUSE;
			default: m = MODE_RUN;
		endcase
		return m;
	endfunction

	// ----------------------------------------------------------------
	// multiplier select pin
	// ----------------------------------------------------------------
	logic mult_sel;

	pin_sync #(
		.WIDTH(1)
	) u_mult_sync (
		.mclk(mclk),
		.srst(srst),
		.ce(ce),
		.pin_in(multiplier_select_in),
		.pin_sync_out(mult_sel)
	);

	// ----------------------------------------------------------------
	// apb slave and registers
	// ----------------------------------------------------------------
	apb_req_t req;
	logic [3:0] dec_b_q;
	logic [3:0] dec_b_d;
	logic [3:0] dec_e_q;
	logic [3:0] dec_e_d;
	logic [3:0] shadow3_q;
	logic [3:0] shadow3_d;
	logic [31:0] prdata_d;
	logic pready_d;
	logic pslverr_d;
	logic access;
	logic hit;
	logic [31:0] rd_mux;
	logic [31:0] status_word;

	assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};
	// one wait state: pready rises in the second access cycle
	assign access = req.psel && req.penable && pready && ce;

	always_comb
	begin
		status_word = '0;
		status_word[1:0] = speed_factor;
		status_word[3:2] = xtal_source;
		status_word[4] = stop_standby;
		status_word[5] = pause_standby;
		status_word[6] = fifo_bypass;
		status_word[7] = mult_sel;
		status_word[8] = host_clock_oe;
		hit = 1'b1;
		case (req.paddr)
			`ADDR_DEC_B: rd_mux = {28'h0, dec_b_q};
			`ADDR_DEC_E: rd_mux = {28'h0, dec_e_q};
			`ADDR_SHADOW3: rd_mux = {28'h0, shadow3_q};
			`ADDR_STATUS: rd_mux = status_word;
			default:
			begin
				rd_mux = 32'h0;
				hit = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		dec_b_d = dec_b_q;
		dec_e_d = dec_e_q;
		shadow3_d = shadow3_q;
		prdata_d = prdata;
		pready_d = pready;
		pslverr_d = pslverr;
		if (ce)
		begin
			pready_d = req.psel && req.penable && !pready;
			pslverr_d = req.psel && req.penable && !pready && !hit;
			if (req.psel && req.penable && !pready)
				prdata_d = req.pwrite ? 32'h0 : rd_mux;
			// write lands only at the edge that completes the access
			if (access && req.pwrite)
			begin
				case (req.paddr)
					`ADDR_DEC_B: dec_b_d = req.pwdata[3:0];
					`ADDR_DEC_E: dec_e_d = req.pwdata[3:0];
					`ADDR_SHADOW3: shadow3_d = req.pwdata[3:0];
					default: dec_b_d = dec_b_q;
				endcase
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			dec_b_q <= `DEC_B_RESET;
			dec_e_q <= `DEC_E_RESET;
			shadow3_q <= `SHADOW3_RESET;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			dec_b_q <= dec_b_d;
			dec_e_q <= dec_e_d;
			shadow3_q <= shadow3_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
		end
	end

	// ----------------------------------------------------------------
	// applied mode, one clock after the register write
	// ----------------------------------------------------------------
	standby_t mode_q;
	standby_t mode_d;
	speed_t speed_d;
	xtal_t xtal_d;
	logic lock_d;
	logic hclk_en_d;
	logic slow_host_q;
	logic slow_host_d;

	always_comb
	begin
		mode_d = mode_q;
		speed_d = speed_factor;
		xtal_d = xtal_source;
		lock_d = fifo_bypass;
		hclk_en_d = host_clock_oe;
		slow_host_d = slow_host_q;
		if (ce)
		begin
			speed_d = decode_speed(dec_b_q, dec_e_q);
			xtal_d = decode_xtal(dec_b_q, mult_sel);
			// 16.9344 MHz without the multiplier only gives half rate
			slow_host_d = dec_b_q[`DEC_B_SRC_BIT] && !mult_sel;
			lock_d = dec_e_q[`DEC_E_LOCK_BIT];
			hclk_en_d = shadow3_q[`SHADOW3_HCLK_EN_BIT];
			case (mode_q)
				MODE_RUN: mode_d = decode_standby(dec_b_q);
				MODE_STOP: mode_d = decode_standby(dec_b_q);
				MODE_PAUSE: mode_d = decode_standby(dec_b_q);
				default: mode_d = MODE_RUN;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			mode_q <= MODE_RUN;
			speed_factor <= SPEED_N1;
			xtal_source <= XTAL_33M;
			fifo_bypass <= 1'b0;
			host_clock_oe <= 1'b0;
			slow_host_q <= 1'b0;
		end
		else
		begin
			mode_q <= mode_d;
			speed_factor <= speed_d;
			xtal_source <= xtal_d;
			fifo_bypass <= lock_d;
			host_clock_oe <= hclk_en_d;
			slow_host_q <= slow_host_d;
		end
	end

	// ----------------------------------------------------------------
	// host clock generator
	// ----------------------------------------------------------------
	logic host_clock;

	nco_clock #(
		.ACC_WIDTH(32)
	) u_host_nco (
		.mclk(mclk),
		.srst(srst),
		.ce(ce),
		.inc(slow_host_q ? INC_SLOW : INC_FAST),
		.clk_q(host_clock)
	);

	// ----------------------------------------------------------------
	// pin gating
	// ----------------------------------------------------------------
	logic host_pin_d;
	logic motor_a_d;
	logic motor_b_d;
	logic motor_oe_d;
	audio_pins_t audio_d;
	logic audio_oe_d;
	logic rate_d;
	logic flag_d;
	logic stop_d;
	logic pause_d;

	always_comb
	begin
		host_pin_d = host_clock_out_pin;
		motor_a_d = motor_drive_out_a;
		motor_b_d = motor_drive_out_b;
		motor_oe_d = motor_drive_oe_a;
		audio_d = audio_out;
		audio_oe_d = audio_oe;
		rate_d = audio_rate_tick;
		flag_d = correction_flag_out;
		stop_d = stop_standby;
		pause_d = pause_standby;
		if (ce)
		begin
			// held low until enabled; the gate is not phase-aligned, so enabling mid-high can give a short first pulse
			host_pin_d = host_clock_oe && host_clock;
			stop_d = (mode_q == MODE_STOP);
			pause_d = (mode_q == MODE_PAUSE);
			motor_a_d = motor_a_in;
			motor_b_d = motor_b_in;
			motor_oe_d = (mode_q != MODE_STOP);
			audio_d = audio_in;
			audio_oe_d = (mode_q == MODE_RUN);
			// output rate follows disc or crystal reference
			rate_d = fifo_bypass ? disc_rate_tick : xtal_rate_tick;
			flag_d = correction_flag_in;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			host_clock_out_pin <= 1'b0;
			motor_drive_out_a <= 1'b0;
			motor_drive_out_b <= 1'b0;
			motor_drive_oe_a <= 1'b0;
			motor_drive_oe_b <= 1'b0;
			audio_out <= '0;
			audio_oe <= 1'b0;
			audio_rate_tick <= 1'b0;
			correction_flag_out <= 1'b0;
			stop_standby <= 1'b0;
			pause_standby <= 1'b0;
			core_active <= 1'b0;
		end
		else
		begin
			host_clock_out_pin <= host_pin_d;
			motor_drive_out_a <= motor_a_d;
			motor_drive_out_b <= motor_b_d;
			motor_drive_oe_a <= motor_oe_d;
			motor_drive_oe_b <= motor_oe_d;
			audio_out <= audio_d;
			audio_oe <= audio_oe_d;
			audio_rate_tick <= rate_d;
			correction_flag_out <= flag_d;
			stop_standby <= stop_d;
			pause_standby <= pause_d;
			// core never stops for standby
			core_active <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== src/nco_clock.sv
`timescale 1ns/1ps
`default_nettype none
module nco_clock #(
	parameter int ACC_WIDTH = 32
)(
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [ACC_WIDTH-1:0] inc,
	output logic clk_q
);
	logic [ACC_WIDTH-1:0] acc_q;
	logic [ACC_WIDTH-1:0] acc_d;
	logic clk_d;
	logic [ACC_WIDTH:0] sum;

	// ------------------------------------------------
	// toggle on accumulator wrap; output is a flop, so
	// changing inc mid-cycle cannot glitch it
	// ------------------------------------------------
	always_comb
	begin
		sum = {1'b0, acc_q} + {1'b0, inc};
		acc_d = acc_q;
		clk_d = clk_q;
		if (ce)
		begin
			acc_d = sum[ACC_WIDTH-1:0];
			clk_d = clk_q ^ sum[ACC_WIDTH];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			acc_q <= '0;
			clk_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			clk_q <= clk_d;
		end
	end
endmodule
`default_nettype wire

// ===== src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
)(
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage1_d;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage2_d;

	always_comb
	begin
		stage1_d = stage1_q;
		stage2_d = stage2_q;
		if (ce)
		begin
			stage1_d = pin_in;
			stage2_d = stage1_q;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			stage1_q <= '0;
			stage2_q <= '0;
		end
		else
		begin
			stage1_q <= stage1_d;
			stage2_q <= stage2_d;
		end
	end

	assign pin_sync_out = stage2_q;
endmodule
`default_nettype wire

// ===== testbench/disc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module disc_ctrl_props (
	input wire logic mclk,
	input wire logic srst,
	input wire logic ce,
	input wire logic pready,
	input wire logic pwrite,
	input wire logic motor_drive_oe_a,
	input wire logic motor_drive_oe_b,
	input wire logic motor_a_in,
	input wire logic motor_b_in,
	input wire logic motor_drive_out_a,
	input wire logic motor_drive_out_b,
	input wire disc_ctrl_pkg::audio_pins_t audio_in,
	input wire disc_ctrl_pkg::audio_pins_t audio_out,
	input wire logic audio_oe,
	input wire logic correction_flag_in,
	input wire logic correction_flag_out,
	input wire logic disc_rate_tick,
	input wire logic xtal_rate_tick,
	input wire logic audio_rate_tick,
	input wire logic fifo_bypass,
	input wire logic core_active,
	input wire logic host_clock_out_pin,
	input wire logic host_clock_oe,
	input wire logic stop_standby,
	input wire logic pause_standby
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	chk_flag_pass: assert property (
		!$past(srst) && $past(ce) |-> correction_flag_out == $past(correction_flag_in))
		else $error("correction flag not passed");
	chk_rate_follow: assert property (
		$stable(fifo_bypass) && !$past(srst) && $past(ce) |-> audio_rate_tick ==
		($past(fifo_bypass) ? $past(disc_rate_tick) : $past(xtal_rate_tick)))
		else $error("audio rate source wrong");
	chk_host_gate: assert property (
		!host_clock_oe && !$past(host_clock_oe) |-> !host_clock_out_pin)
		else $error("host clock while disabled");
	chk_core_alive: assert property (
		!$past(srst) && !$past(srst, 2) |-> core_active)
		else $error("core inactive");
	chk_stop_motor: assert property (
		stop_standby [*3] |-> !motor_drive_oe_a && !motor_drive_oe_b)
		else $error("motor driven in stop");
	chk_pause_motor: assert property (
		pause_standby [*3] |-> motor_drive_oe_a && motor_drive_oe_b)
		else $error("motor floated in pause");
	chk_stby_audio: assert property (
		(stop_standby || pause_standby) [*3] |-> !audio_oe)
		else $error("audio driven in standby");
	chk_lock_write: assert property (
		fifo_bypass != $past(fifo_bypass) |-> $past(pready && pwrite, 2))
		else $error("lock changed without write");
	chk_motor_pass: assert property (
		!$past(srst) && $past(ce) |-> motor_drive_out_a == $past(motor_a_in) &&
		motor_drive_out_b == $past(motor_b_in))
		else $error("motor drive not passed");
	chk_audio_pass: assert property (
		!$past(srst) && $past(ce) |-> audio_out == $past(audio_in))
		else $error("audio data not passed");
endmodule
bind disc_speed_standby_ctrl disc_ctrl_props u_props (.mclk, .srst, .ce, .pready, .pwrite,
	.motor_drive_oe_a, .motor_drive_oe_b, .motor_a_in, .motor_b_in, .motor_drive_out_a,
	.motor_drive_out_b, .audio_in, .audio_out, .audio_oe, .correction_flag_in,
	.correction_flag_out, .disc_rate_tick, .xtal_rate_tick, .audio_rate_tick,
	.fifo_bypass, .core_active, .host_clock_out_pin, .host_clock_oe,
	.stop_standby, .pause_standby);
`default_nettype wire

// ===== testbench/disc_speed_standby_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "disc_ctrl_params.svh"
module disc_speed_standby_ctrl_tb;
	import disc_ctrl_pkg::*;
	logic mclk, srst, ce, multiplier_select_in, motor_a_in, motor_b_in;
	logic correction_flag_in, disc_rate_tick, xtal_rate_tick, pready, pslverr;
	logic motor_drive_out_a, motor_drive_out_b, motor_drive_oe_a, motor_drive_oe_b;
	logic audio_oe, correction_flag_out, audio_rate_tick, fifo_bypass, core_active;
	logic host_clock_out_pin, host_clock_oe, stop_standby, pause_standby;
	logic [31:0] prdata;
	logic [7:0] tick;
	logic [15:0] r;
	audio_pins_t audio_in, audio_out;
	speed_t speed_factor;
	xtal_t xtal_source;
	apb_req_t req;
	int bad_count = 0;
	int n_checks = 0;
	int k, cnt;
	// b, e, pin, speed, crystal, slow host clock
	// combos software avoids are only decoded, no data is captured
	logic [15:0] rows [13] = '{16'h0000, 16'h0090, 16'h400C, 16'h4088, 16'h8020,
		16'h80B0, 16'hC02C, 16'hC0A8, 16'h0840, 16'h08D0, 16'h484C, 16'h48C8, 16'h88D0};
	host_mcu_model mcu (.mclk, .pready, .pslverr, .prdata, .req);
	disc_speed_standby_ctrl DUT (.mclk, .srst, .ce, .paddr(req.paddr), .psel(req.psel),
		.penable(req.penable), .pwrite(req.pwrite), .pwdata(req.pwdata), .prdata, .pready,
		.pslverr, .multiplier_select_in, .motor_a_in, .motor_b_in, .motor_drive_out_a,
		.motor_drive_out_b, .motor_drive_oe_a, .motor_drive_oe_b, .audio_in, .audio_out,
		.audio_oe, .correction_flag_in, .correction_flag_out, .disc_rate_tick,
		.xtal_rate_tick, .audio_rate_tick, .fifo_bypass, .core_active, .host_clock_out_pin,
		.host_clock_oe, .speed_factor, .xtal_source, .stop_standby, .pause_standby);
	task automatic chk(input logic [31:0] s, e, input string n);
		n_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic edges(output int c);
		logic p;
		c = 0;
		p = host_clock_out_pin;
		repeat (1000)
		begin
			@(posedge mclk);
			c += int'(host_clock_out_pin & !p);
			p = host_clock_out_pin;
		end
	endtask
	task automatic stby(input logic [3:0] b, input logic m, a);
		mcu.xfer(`ADDR_DEC_B, 1'b1, {28'h0, b});
		repeat (4) @(posedge mclk);
		chk({motor_drive_oe_a, motor_drive_oe_b}, {m, m}, "motor oe");
		chk(audio_oe, a, "audio oe");
		chk(core_active, 1'b1, "core");
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// disc tick at half the crystal tick rate, inside the followed range
	always @(posedge mclk)
	begin
		tick <= tick + 8'h01;
		motor_a_in <= tick[0];
		motor_b_in <= tick[1];
		audio_in <= tick[6:2];
		correction_flag_in <= tick[3];
		disc_rate_tick <= tick[2:0] == 3'h0;
		xtal_rate_tick <= tick[1:0] == 2'h0;
	end
	initial
	begin
		repeat (60000) @(posedge mclk);
		bad_count++;
		wrap_up();
	end
	initial
	begin
		{srst, ce, multiplier_select_in, tick} = {3'h6, 8'h00};
		{motor_a_in, motor_b_in, audio_in, correction_flag_in} = '0;
		{disc_rate_tick, xtal_rate_tick} = 2'h0;
		repeat (4) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		for (k = 0; k < 3; k++)
		begin
			mcu.xfer(8'(k * 4), 1'b0, 32'h0);
			chk(mcu.rdata, 32'h0, "reset value");
		end
		mcu.xfer(`ADDR_SHADOW3, 1'b1, 32'h1);
		foreach (rows[i])
		begin
			r = rows[i];
			multiplier_select_in <= r[7];
			mcu.xfer(`ADDR_DEC_B, 1'b1, {28'h0, r[15:12]});
			mcu.xfer(`ADDR_DEC_E, 1'b1, {28'h0, r[11:8]});
			repeat (8) @(posedge mclk);
			chk(speed_factor, r[6:5], "speed");
			chk(xtal_source, r[4:3], "crystal");
			mcu.xfer(`ADDR_STATUS, 1'b0, 32'h0);
			chk(mcu.rdata[3:0], {r[4:3], r[6:5]}, "status");
			edges(cnt);
			k = r[2] ? 45 : 90;
			chk(cnt >= k && cnt <= k + 1, 1'b1, "host rate");
		end
		stby(4'h1, 1'b0, 1'b0);
		chk(stop_standby, 1'b1, "stop");
		chk(host_clock_oe, 1'b1, "host oe");
		edges(cnt);
		chk(cnt >= 90 && cnt <= 91, 1'b1, "host in stop");
		stby(4'h2, 1'b1, 1'b0);
		chk(pause_standby, 1'b1, "pause");
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({motor_drive_oe_a, motor_drive_oe_b}, 2'h0, "reset oe");
		srst <= 1'b0;
		repeat (4) @(posedge mclk);
		chk(audio_oe, 1'b1, "audio after reset");
		stby(4'h3, 1'b1, 1'b1);
		mcu.xfer(`ADDR_DEC_E, 1'b1, 32'h1);
		repeat (2) @(posedge mclk);
		chk(fifo_bypass, 1'b1, "lock");
		ce <= 1'b0;
		repeat (3) @(posedge mclk);
		ce <= 1'b1;
		mcu.xfer(`ADDR_DEC_E, 1'b1, 32'h0);
		repeat (2) @(posedge mclk);
		chk(fifo_bypass, 1'b0, "unlock");
		mcu.xfer(8'h20, 1'b1, 32'h5);
		chk(mcu.err, 1'b1, "unmapped");
		mcu.xfer(`ADDR_SHADOW3, 1'b1, 32'h0);
		repeat (4) @(posedge mclk);
		edges(cnt);
		chk(cnt, 32'h0, "host off");
		wrap_up();
	end
endmodule
`default_nettype wire

// ===== testbench/host_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
	input wire logic mclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output disc_ctrl_pkg::apb_req_t req
);
	logic [31:0] rdata;
	logic err;
	initial req = '0;
	// caller stands just after a rising edge; the release costs one idle cycle
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		req <= '0;
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire
